// ==== shared/bwr_pkg.sv ====
// constants and types for the board watchdog, reset and front LED logic
// Behaviour
// RULE1 - watchdog period selectable among 2, 10, 50 or 255 seconds
// RULE2 - after any system reset the watchdog is idle, needs no servicing
// RULE3 - first service request after reset arms the watchdog
// RULE4 - armed and service gap exceeds period: issue full board reset
// RULE5 - once armed, stays armed until next system reset
// RULE6 - period select writable anytime, new value used for later checks
// RULE7 - host must service faster than the selected period once armed
// RULE8 - handle switch actuation gives one power-button pulse
// RULE9 - handle open 4 seconds or longer forces soft-off S4/S5
// RULE10 - in override soft-off, open then close handle returns to S0
// RULE11 - handle open during power-up sends board to S4/S5
// RULE12 - setting makes handle act as reset button instead of power button
// RULE13 - settings can disable reset button and handle switch
// RULE14 - backplane reset input low resets board like the reset button
// RULE15 - power LED green only with supplies good and reset released
// RULE16 - in S4/S5: power LED off, general LED green, storage LED off
// RULE17 - in S3: power LED off, general LED off, storage LED green
// RULE18 - healthy S0 shows steady green power LED
// RULE19 - handle open makes power LED blink yellow
// RULE20 - power fault shows steady red power LED
// RULE21 - soft failure flag blinks power LED red until cleared
// RULE22 - general LED green from control bit, red from processor output
// RULE23 - service is one write strobe and restarts count from zero
// RULE24 - switch inputs synchronised and debounced, LEDs blink near 1 Hz
package bwr_pkg;
  // ========================================================
  // clock and time base
  localparam int CLK_HZ = 125_000_000;
  localparam int TICK_US = 1000;
  localparam int TICK_W = 17;
  localparam int MS_W = 18;
  localparam logic [TICK_W-1:0] TICK_CYCLES_DEF =
    TICK_W'(CLK_HZ / 1_000_000 * TICK_US);
  // ========================================================
  // watchdog periods, seconds as printed and in ms ticks
  localparam int WD_S_0 = 2;
  localparam int WD_S_1 = 10;
  localparam int WD_S_2 = 50;
  localparam int WD_S_3 = 255;
  localparam logic [MS_W-1:0] WD_MS_0_DEF = MS_W'(WD_S_0 * 1000);
  localparam logic [MS_W-1:0] WD_MS_1_DEF = MS_W'(WD_S_1 * 1000);
  localparam logic [MS_W-1:0] WD_MS_2_DEF = MS_W'(WD_S_2 * 1000);
  localparam logic [MS_W-1:0] WD_MS_3_DEF = MS_W'(WD_S_3 * 1000);
  localparam int WD_SEL_W = 2;
  // ========================================================
  // handle override and housekeeping times in ms ticks
  localparam int OVR_S = 4;
  localparam logic [MS_W-1:0] OVR_MS_DEF = MS_W'(OVR_S * 1000);
  localparam int DEB_W = 4;
  localparam logic [DEB_W-1:0] DEB_MS = 4'ha;
  localparam logic [4:0] BOOT_MS = 5'h14;
  localparam logic [8:0] BLINK_MS = 9'h1f4;
  // ========================================================
  // synchroniser bit positions; first three are debounced
  localparam int SI_HANDLE = 0;
  localparam int SI_BUTTON = 1;
  localparam int SI_BACKPL = 2;
  localparam int SI_SUPPLY = 3;
  localparam int SI_FAULT = 4;
  localparam int SI_GPRED = 5;
  localparam int SI_S3 = 6;
  localparam int SI_S45 = 7;
  localparam int SI_ACT_A = 8;
  localparam int SI_ACT_B = 9;
  localparam int SYNC_N = 10;
  localparam int DB_N = 3;
  localparam logic [SYNC_N-1:0] SYNC_RST = 10'h000;
  localparam logic [1:0] LED_OFF = 2'h0;
  typedef enum logic [1:0] {
    PWR_BOOT, PWR_S0, PWR_OFF, PWR_OFF_OPEN
  } bwr_pwr_t;
endpackage : bwr_pkg

// ==== hdl/bwr_board_ctrl.sv ====
// board watchdog, reset sources, power state and front LED driver
`timescale 1ns/1ps
module bwr_board_ctrl #(
  parameter logic [bwr_pkg::TICK_W-1:0] TICK_CYCLES =
    bwr_pkg::TICK_CYCLES_DEF,
  parameter logic [bwr_pkg::MS_W-1:0] WD_MS_0 = bwr_pkg::WD_MS_0_DEF,
  parameter logic [bwr_pkg::MS_W-1:0] WD_MS_1 = bwr_pkg::WD_MS_1_DEF,
  parameter logic [bwr_pkg::MS_W-1:0] WD_MS_2 = bwr_pkg::WD_MS_2_DEF,
  parameter logic [bwr_pkg::MS_W-1:0] WD_MS_3 = bwr_pkg::WD_MS_3_DEF,
  parameter logic [bwr_pkg::MS_W-1:0] OVR_MS = bwr_pkg::OVR_MS_DEF
) (
  input wire logic core_clk,
  input wire logic rst,
  // host software side, same clock
  input wire logic [bwr_pkg::WD_SEL_W-1:0] wd_period_sel,
  input wire logic wd_service,
  input wire logic soft_failure_flag,
  input wire logic general_led_green_bit,
  input wire logic cfg_handle_reset_mode,
  input wire logic cfg_handle_disable,
  input wire logic cfg_button_disable,
  // board pins, asynchronous
  input wire logic handle_open_in,
  input wire logic reset_button_in_n,
  input wire logic backplane_reset_in_n,
  input wire logic supplies_ok_in,
  input wire logic power_fault_in,
  input wire logic gp_red_gpio_in,
  input wire logic sleep_s3_in,
  input wire logic sleep_s45_in,
  input wire logic storage_act_a_in,
  input wire logic storage_act_b_in,
  // outputs
  output logic board_reset_out,
  output logic power_button_pulse,
  output logic power_override_pulse,
  output logic soft_off_out,
  output logic wd_armed_out,
  output logic wd_expired_out,
  output logic [1:0] power_ok_led,
  output logic [1:0] general_purpose_led,
  output logic [1:0] storage_activity_led
);
  import bwr_pkg::*;

  // ========================================================
  // declarations
  logic [TICK_W-1:0] tick_cnt_reg;
  logic tick_reg;
  logic [SYNC_N-1:0] pin_vec;
  logic [SYNC_N-1:0] sync1_reg;
  logic [SYNC_N-1:0] sync2_reg;
  logic [DB_N-1:0] db_reg;
  logic [DEB_W-1:0] db_cnt_reg [DB_N];
  logic [8:0] blink_cnt_reg;
  logic blink_reg;
  logic handle_open;
  logic handle_prev_reg;
  logic handle_rise;
  logic handle_pb;
  logic handle_rst;
  logic button_pressed;
  logic backplane_rst;
  bwr_pwr_t pwr_reg;
  logic [4:0] boot_cnt_reg;
  logic [MS_W-1:0] ovr_cnt_reg;
  logic pb_pulse_reg;
  logic ovr_pulse_reg;
  logic wd_armed_reg;
  logic wd_expired_reg;
  logic [MS_W-1:0] wd_cnt_reg;
  logic [MS_W-1:0] wd_limit;
  logic reset_next;
  logic reset_reg;
  logic in_s45;
  logic in_s3;
  logic healthy;
  logic [1:0] pg_reg;
  logic [1:0] gp_reg;
  logic [1:0] hd_reg;

  // period select decode, read afresh each cycle
  function automatic logic [MS_W-1:0] wd_period_ms(
    input logic [WD_SEL_W-1:0] sel
  );
    logic [MS_W-1:0] ms;
    ms = WD_MS_0;
    unique case (sel)
      2'h0: ms = WD_MS_0;
      2'h1: ms = WD_MS_1;
      2'h2: ms = WD_MS_2;
      2'h3: ms = WD_MS_3;
    endcase
    return ms;
  endfunction : wd_period_ms

  // ========================================================
  // millisecond tick shared by all slow counters
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tick_cnt_reg <= '0;
      tick_reg <= 1'h0;
    end else if (tick_cnt_reg == TICK_CYCLES - 1'b1) begin
      tick_cnt_reg <= '0;
      tick_reg <= 1'h1;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 1'b1;
      tick_reg <= 1'h0;
    end
  end

  // ========================================================
  // pin synchronisers; active-low pins flipped before capture
  assign pin_vec[SI_HANDLE] = handle_open_in;
  assign pin_vec[SI_BUTTON] = ~reset_button_in_n;
  assign pin_vec[SI_BACKPL] = ~backplane_reset_in_n;
  assign pin_vec[SI_SUPPLY] = supplies_ok_in;
  assign pin_vec[SI_FAULT] = power_fault_in;
  assign pin_vec[SI_GPRED] = gp_red_gpio_in;
  assign pin_vec[SI_S3] = sleep_s3_in;
  assign pin_vec[SI_S45] = sleep_s45_in;
  assign pin_vec[SI_ACT_A] = storage_act_a_in;
  assign pin_vec[SI_ACT_B] = storage_act_b_in;

  // two stages, second one is the only reader of the first
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sync1_reg <= SYNC_RST;
      sync2_reg <= SYNC_RST;
    end else begin
      sync1_reg <= pin_vec;
      sync2_reg <= sync1_reg;
    end
  end

  // ========================================================
  // debouncers: a new level must hold DEB_MS ticks to be taken
  for (genvar g = 0; g < DB_N; g++) begin : g_deb
    always_ff @(posedge core_clk) begin
      if (rst) begin
        db_reg[g] <= 1'h0;
        db_cnt_reg[g] <= '0;
      end else if (sync2_reg[g] == db_reg[g]) begin
        db_cnt_reg[g] <= '0;
      end else if (tick_reg) begin
        if (db_cnt_reg[g] == DEB_MS - 1'b1) begin
          db_reg[g] <= sync2_reg[g]; // see RULE24
          db_cnt_reg[g] <= '0;
        end else begin
          db_cnt_reg[g] <= db_cnt_reg[g] + 1'b1;
        end
      end
    end
  end

  // switch meanings after debouncing and configuration
  assign handle_open = db_reg[SI_HANDLE];
  assign handle_rise = handle_open & ~handle_prev_reg;
  assign handle_pb = ~cfg_handle_reset_mode & ~cfg_handle_disable;
  assign handle_rst = cfg_handle_reset_mode & ~cfg_handle_disable;
  assign button_pressed = db_reg[SI_BUTTON] & ~cfg_button_disable;
  assign backplane_rst = db_reg[SI_BACKPL];

  always_ff @(posedge core_clk) begin
    if (rst) begin
      handle_prev_reg <= 1'h0;
    end else begin
      handle_prev_reg <= handle_open;
    end
  end

  // ========================================================
  // blink source, toggles every BLINK_MS for about 1 Hz
  always_ff @(posedge core_clk) begin
    if (rst) begin
      blink_cnt_reg <= '0;
      blink_reg <= 1'h0;
    end else if (tick_reg) begin
      if (blink_cnt_reg == BLINK_MS - 1'b1) begin
        blink_cnt_reg <= '0;
        blink_reg <= ~blink_reg; // see RULE24
      end else begin
        blink_cnt_reg <= blink_cnt_reg + 1'b1;
      end
    end
  end

  // ========================================================
  // power state: boot check, override, open/close recovery
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pwr_reg <= PWR_BOOT;
      boot_cnt_reg <= '0;
      ovr_cnt_reg <= '0;
      pb_pulse_reg <= 1'h0;
      ovr_pulse_reg <= 1'h0;
    end else begin
      pb_pulse_reg <= 1'h0;
      ovr_pulse_reg <= 1'h0;
      unique case (pwr_reg)
        // wait past the debounce time so the handle level is real
        PWR_BOOT: begin
          if (tick_reg) begin
            if (boot_cnt_reg == BOOT_MS - 1'b1) begin
              pwr_reg <= (handle_open && handle_pb) ?
                PWR_OFF : PWR_S0; // see RULE11
            end else begin
              boot_cnt_reg <= boot_cnt_reg + 1'b1;
            end
          end
        end
        PWR_S0: begin
          pb_pulse_reg <= handle_rise & handle_pb; // see RULE8
          if (!(handle_open && handle_pb)) begin
            ovr_cnt_reg <= '0;
          end else if (tick_reg) begin
            if (ovr_cnt_reg == OVR_MS - 1'b1) begin
              ovr_cnt_reg <= '0;
              ovr_pulse_reg <= 1'h1;
              pwr_reg <= PWR_OFF; // see RULE9
            end else begin
              ovr_cnt_reg <= ovr_cnt_reg + 1'b1;
            end
          end
        end
        // the handle that caused the override is still open here,
        // so only a fresh opening edge starts the way back
        PWR_OFF: begin
          if (handle_rise && handle_pb) begin
            pwr_reg <= PWR_OFF_OPEN;
          end
        end
        PWR_OFF_OPEN: begin
          if (!handle_open && handle_pb) begin
            pwr_reg <= PWR_S0; // see RULE10
          end
        end
      endcase
    end
  end

  // ========================================================
  // board watchdog: idle after reset, armed by first service
  assign wd_limit = wd_period_ms(wd_period_sel); // see RULE1 RULE6

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wd_armed_reg <= 1'h0; // see RULE2
      wd_cnt_reg <= '0;
      wd_expired_reg <= 1'h0;
    end else if (wd_service) begin
      wd_armed_reg <= 1'h1; // see RULE3 RULE5
      wd_cnt_reg <= '0; // see RULE23
    end else if (wd_armed_reg && tick_reg) begin
      // one tick beyond the period means the gap was exceeded
      if (wd_cnt_reg >= wd_limit) begin
        wd_expired_reg <= 1'h1; // see RULE4
      end else begin
        wd_cnt_reg <= wd_cnt_reg + 1'b1;
      end
    end
  end

  // ========================================================
  // board reset request; watchdog expiry holds it until system reset, other sources only while active
  assign reset_next = wd_expired_reg // see RULE4
    | button_pressed // see RULE13
    | (handle_open & handle_rst) // see RULE12
    | backplane_rst; // see RULE14

  always_ff @(posedge core_clk) begin
    if (rst) begin
      reset_reg <= 1'h0;
    end else begin
      reset_reg <= reset_next;
    end
  end

  // ========================================================
  // LED indication, sleep states take precedence
  assign in_s45 = (pwr_reg == PWR_OFF) || (pwr_reg == PWR_OFF_OPEN)
    || sync2_reg[SI_S45];
  assign in_s3 = sync2_reg[SI_S3] & ~in_s45;
  assign healthy = sync2_reg[SI_SUPPLY] & ~reset_reg
    & (pwr_reg != PWR_BOOT);

  // power LED bits are {red, green}; both lit reads as yellow
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pg_reg <= LED_OFF;
    end else if (in_s45 || in_s3) begin
      pg_reg <= LED_OFF; // see RULE16 RULE17
    end else if (sync2_reg[SI_FAULT]) begin
      pg_reg <= 2'h2; // see RULE20
    end else if (handle_open) begin
      pg_reg <= {blink_reg, blink_reg}; // see RULE19
    end else if (soft_failure_flag) begin
      pg_reg <= {blink_reg, 1'h0}; // see RULE21
    end else if (healthy) begin
      pg_reg <= 2'h1; // see RULE15 RULE18
    end else begin
      pg_reg <= LED_OFF;
    end
  end

  // general LED bits are {red, green}
  always_ff @(posedge core_clk) begin
    if (rst) begin
      gp_reg <= LED_OFF;
    end else if (in_s45) begin
      gp_reg <= 2'h1; // see RULE16
    end else if (in_s3) begin
      gp_reg <= LED_OFF; // see RULE17
    end else begin
      gp_reg <= {sync2_reg[SI_GPRED], general_led_green_bit}; // see RULE22
    end
  end

  // storage LED bits are {yellow, green}, activity otherwise
  always_ff @(posedge core_clk) begin
    if (rst) begin
      hd_reg <= LED_OFF;
    end else if (in_s45) begin
      hd_reg <= LED_OFF; // see RULE16
    end else if (in_s3) begin
      hd_reg <= 2'h1; // see RULE17
    end else begin
      hd_reg <= {sync2_reg[SI_ACT_B], sync2_reg[SI_ACT_A]};
    end
  end

  // ========================================================
  // outputs, all from flip-flops except soft_off_out, decoded from pwr_reg and the S4/S5 pin
  assign board_reset_out = reset_reg;
  assign power_button_pulse = pb_pulse_reg;
  assign power_override_pulse = ovr_pulse_reg;
  assign soft_off_out = in_s45;
  assign wd_armed_out = wd_armed_reg;
  assign wd_expired_out = wd_expired_reg;
  assign power_ok_led = pg_reg;
  assign general_purpose_led = gp_reg;
  assign storage_activity_led = hd_reg;

endmodule : bwr_board_ctrl

// ==== tb/bwr_board_ctrl_monitor.sv ====
// checker for the watchdog, reset and switch outputs
`timescale 1ns/1ps
module bwr_board_ctrl_monitor #(
  parameter logic [bwr_pkg::TICK_W-1:0] TICK_CYCLES = 17'h0_0004,
  parameter logic [bwr_pkg::MS_W-1:0] WD_MS_0 = 18'h0_0005,
  parameter logic [bwr_pkg::MS_W-1:0] WD_MS_1 = 18'h0_000a,
  parameter logic [bwr_pkg::MS_W-1:0] WD_MS_2 = 18'h0_0014,
  parameter logic [bwr_pkg::MS_W-1:0] WD_MS_3 = 18'h0_0028
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [bwr_pkg::WD_SEL_W-1:0] wd_period_sel,
  input wire logic wd_service,
  input wire logic board_reset_out,
  input wire logic power_button_pulse,
  input wire logic power_override_pulse,
  input wire logic soft_off_out,
  input wire logic wd_armed_out,
  input wire logic wd_expired_out
);
  import bwr_pkg::*;
  localparam int TC = TICK_CYCLES;
  // ========================================
  // cycles since last service; limit follows the live select
  logic [15:0] gap_reg;
  int lim;
  assign lim = int'(wd_period_sel[1] ?
    (wd_period_sel[0] ? WD_MS_3 : WD_MS_2)
    : (wd_period_sel[0] ? WD_MS_1 : WD_MS_0));
  always_ff @(posedge core_clk) begin
    if (rst || wd_service) begin
      gap_reg <= 16'h0000;
    end else if (gap_reg != 16'hffff) begin
      gap_reg <= gap_reg + 16'h0001;
    end
  end
  default clocking mc @(posedge core_clk); endclocking
  default disable iff (rst);
  // ========================================
  // properties
  arm_on_svc_a: assert property (wd_service |=> wd_armed_out)
    else $error("no arm after service");
  idle_stays_a: assert property (
    !wd_armed_out && !wd_service |=> !wd_armed_out && !wd_expired_out)
    else $error("idle watchdog woke");
  armed_sticky_a: assert property (wd_armed_out |=> wd_armed_out)
    else $error("watchdog disarmed");
  early_exp_a: assert property (
    $rose(wd_expired_out) |-> int'(gap_reg) >= (lim - 1) * TC)
    else $error("expiry too early");
  late_exp_a: assert property (
    wd_armed_out && int'(gap_reg) > (lim + 2) * TC + 4 |-> wd_expired_out)
    else $error("expiry too late");
  exp_reset_a: assert property (
    $rose(wd_expired_out) |=> board_reset_out)
    else $error("expiry gave no reset");
  pulse_once_a: assert property (
    power_button_pulse |=> !power_button_pulse)
    else $error("button pulse too long");
  override_off_a: assert property (
    power_override_pulse |=> soft_off_out[*3])
    else $error("override left board on");
endmodule : bwr_board_ctrl_monitor
bind bwr_board_ctrl bwr_board_ctrl_monitor #(.TICK_CYCLES(TICK_CYCLES),
  .WD_MS_0(WD_MS_0), .WD_MS_1(WD_MS_1), .WD_MS_2(WD_MS_2),
  .WD_MS_3(WD_MS_3)) i_bwr_board_ctrl_monitor (.*);

// ==== tb/bwr_far_side.sv ====
// far side model: host servicing, panel switches, backplane line
`timescale 1ns/1ps
module bwr_far_side (
  input wire logic core_clk,
  input wire logic svc_kick,
  input wire logic svc_en,
  input wire logic [7:0] svc_gap,
  input wire logic handle_req,
  input wire logic button_req,
  input wire logic backplane_req,
  output logic wd_service,
  output logic handle_open_in,
  output logic reset_button_in_n,
  output logic backplane_reset_in_n
);
  logic [7:0] cnt_reg = 8'h00;
  // host: one-off kicks or periodic service inside the period
  initial wd_service = 1'b0;
  always @(posedge core_clk) begin
    cnt_reg <= (svc_en && cnt_reg < svc_gap) ? cnt_reg + 8'h01 : 8'h00;
    wd_service <= #1 svc_kick || (svc_en && cnt_reg >= svc_gap);
  end
  // switches are always driven, so no stale level can hide
  assign handle_open_in = handle_req;
  assign reset_button_in_n = ~button_req;
  assign backplane_reset_in_n = ~backplane_req;
endmodule : bwr_far_side

// ==== tb/bwr_board_ctrl_test.sv ====
// bench for the board watchdog, reset and front LED block
`timescale 1ns/1ps
module bwr_board_ctrl_test;
  import bwr_pkg::*;
  localparam int LIM [4] = '{5, 10, 20, 40};
  typedef struct {string nm; logic [1:0] ex;} bwr_note_t;
  logic core_clk, rst, soft_failure_flag, general_led_green_bit;
  logic cfg_handle_reset_mode, cfg_handle_disable, cfg_button_disable;
  logic supplies_ok_in, power_fault_in, gp_red_gpio_in, sleep_s3_in;
  logic sleep_s45_in, storage_act_a_in, storage_act_b_in, svc_kick, svc_en;
  logic handle_req, button_req, backplane_req, wd_service, handle_open_in;
  logic reset_button_in_n, backplane_reset_in_n, board_reset_out;
  logic power_button_pulse, power_override_pulse, soft_off_out;
  logic wd_armed_out, wd_expired_out;
  logic [1:0] wd_period_sel, power_ok_led, general_purpose_led;
  logic [1:0] storage_activity_led;
  logic [7:0] svc_gap, lfsr_reg;
  bwr_note_t notes[$];
  event res_ev;
  int miscompares = 0;
  int total_checks = 0;
  // short ms tick keeps watchdog periods to at most 160 cycles;
  // the override keeps its real 4000 ticks, so that limit is exercised
  bwr_board_ctrl #(.TICK_CYCLES(17'h0_0004), .WD_MS_0(18'h0_0005),
    .WD_MS_1(18'h0_000a), .WD_MS_2(18'h0_0014), .WD_MS_3(18'h0_0028))
    i_bwr_board_ctrl (.*);
  bwr_far_side i_bwr_far_side (.*);
  always #4 core_clk = ~core_clk;
  // ========================================
  // helpers
  function automatic logic [7:0] lfsr(logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr
  function automatic logic [1:0] obs(string nm);
    case (nm)
      "armed": return {1'b0, wd_armed_out};
      "expired": return {1'b0, wd_expired_out};
      "breset": return {1'b0, board_reset_out};
      "soff": return {1'b0, soft_off_out};
      "pbtn": return {1'b0, power_button_pulse};
      "povr": return {1'b0, power_override_pulse};
      "gled": return general_purpose_led;
      "sled": return storage_activity_led;
      default: return power_ok_led;
    endcase
  endfunction : obs
  task automatic cyc(int n);
    if (n > 0) begin
      repeat (n) @(posedge core_clk);
      #1;
    end
  endtask : cyc
  task automatic note(string nm, logic [1:0] ex, int n = 0);
    cyc(n);
    notes.push_back('{nm, ex});
    ->res_ev;
  endtask : note
  task automatic wait_for(string nm, logic [1:0] ex, int lim);
    for (int i = 0; i < lim && obs(nm) !== ex; i++) cyc(1);
    note(nm, ex);
  endtask : wait_for
  task automatic kick();
    svc_kick = 1'b1;
    cyc(1);
    svc_kick = 1'b0;
  endtask : kick
  task automatic do_reset();
    rst = 1'b1;
    cyc(20);
    rst = 1'b0;
  endtask : do_reset
  task automatic close_out();
    #1;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out
  // oldest note is matched against the output it names
  initial begin
    bwr_note_t n;
    forever begin
      @(res_ev);
      while (notes.size() > 0) begin
        n = notes.pop_front();
        total_checks++;
        if (obs(n.nm) !== n.ex) begin
          miscompares++;
          $display("[FAIL] %s expected %b seen %b", n.nm, n.ex, obs(n.nm));
        end
      end
    end
  end
  // hang guard: the whole sequence needs about 25k cycles
  initial begin
    #400000;
    miscompares++;
    close_out();
  end
  // ========================================
  // main sequence
  initial begin
    core_clk = 1'b0;
    rst = 1'b1;
    {soft_failure_flag, cfg_handle_reset_mode, cfg_handle_disable} = '0;
    {cfg_button_disable, power_fault_in, sleep_s3_in, sleep_s45_in} = '0;
    {storage_act_a_in, storage_act_b_in, svc_kick, svc_en} = '0;
    {handle_req, button_req, backplane_req} = '0;
    {supplies_ok_in, gp_red_gpio_in} = 2'h3;
    wd_period_sel = 2'h0;
    svc_gap = 8'h08;
    lfsr_reg = lfsr(8'h3e);
    general_led_green_bit = lfsr_reg[0];
    cyc(1);
    do_reset();
    note("armed", 2'h0, 150);
    note("breset", 2'h0);
    note("pled", 2'h1);
    note("gled", {1'b1, lfsr_reg[0]});
    gp_red_gpio_in = 1'b0;
    for (int s = 0; s < 4; s++) begin
      do_reset();
      wd_period_sel = 2'(s);
      note("armed", 2'h0, 30);
      kick();
      note("armed", 2'h1, 2);
      note("expired", 2'h0, LIM[s] * 4 - 4);
      wait_for("expired", 2'h1, 20);
      note("breset", 2'h1, 1);
    end
    // random spacing and random period, then a shorter period
    do_reset();
    kick();
    svc_en = 1'b1;
    for (int s = 0; s < 30; s++) begin
      lfsr_reg = lfsr(lfsr_reg);
      svc_gap = {4'h0, lfsr_reg[3:0]};
      wd_period_sel = lfsr_reg[5:4] | 2'h1;
      cyc(20);
    end
    note("expired", 2'h0);
    wd_period_sel = 2'h3;
    cyc(20);
    svc_en = 1'b0;
    wd_period_sel = 2'h1;
    wait_for("expired", 2'h1, 60);
    note("armed", 2'h1);
    // handle: pulse, override, then open and close back to S0
    do_reset();
    cyc(150);
    handle_req = 1'b1;
    wait_for("pbtn", 2'h1, 80);
    wait_for("povr", 2'h1, 16100);
    note("soff", 2'h1, 4);
    note("pled", 2'h0);
    note("gled", 2'h1);
    note("sled", 2'h0);
    handle_req = 1'b0;
    note("soff", 2'h1, 80);
    handle_req = 1'b1;
    cyc(80);
    handle_req = 1'b0;
    note("soff", 2'h0, 80);
    note("pled", 2'h1);
    handle_req = 1'b1;
    do_reset();
    note("soff", 2'h1, 200);
    handle_req = 1'b0;
    cfg_handle_reset_mode = 1'b1;
    do_reset();
    cyc(150);
    handle_req = 1'b1;
    wait_for("breset", 2'h1, 80);
    {handle_req, cfg_handle_reset_mode} = 2'h0;
    // disabled sources do nothing, open handle still shows
    {cfg_handle_disable, cfg_button_disable} = 2'h3;
    do_reset();
    cyc(150);
    {handle_req, button_req} = 2'h3;
    wait_for("pled", 2'h3, 4200);
    note("breset", 2'h0);
    note("soff", 2'h0);
    {handle_req, cfg_handle_disable, cfg_button_disable} = 3'h0;
    wait_for("breset", 2'h1, 80);
    button_req = 1'b0;
    do_reset();
    cyc(150);
    backplane_req = 1'b1;
    wait_for("breset", 2'h1, 80);
    backplane_req = 1'b0;
    // power LED priority, then the sleep states
    do_reset();
    cyc(150);
    {power_fault_in, soft_failure_flag} = 2'h3;
    note("pled", 2'h2, 8);
    power_fault_in = 1'b0;
    wait_for("pled", 2'h0, 4200);
    wait_for("pled", 2'h2, 4200);
    soft_failure_flag = 1'b0;
    note("pled", 2'h1, 8);
    // supplies out of tolerance take the green away
    supplies_ok_in = 1'b0;
    general_led_green_bit = lfsr_reg[2];
    note("pled", 2'h0, 8);
    note("gled", {1'b0, lfsr_reg[2]});
    supplies_ok_in = 1'b1;
    note("pled", 2'h1, 8);
    {storage_act_a_in, storage_act_b_in} = lfsr_reg[1:0];
    note("sled", {lfsr_reg[0], lfsr_reg[1]}, 8);
    sleep_s3_in = 1'b1;
    note("pled", 2'h0, 8);
    note("gled", 2'h0);
    note("sled", 2'h1);
    {sleep_s3_in, sleep_s45_in} = 2'h1;
    note("soff", 2'h1, 8);
    note("gled", 2'h1);
    close_out();
  end
endmodule : bwr_board_ctrl_test
